/* File: hw/waveform_ram_sequencer.sv */
// waveform ram with apb load/retrieve and triggered segment playback
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "wram_consts.svh"

// Overview of operation
// - 1024x32 ram usable only in quadrature upconvert or interpolating converter mode.
// - enable bit picks load/retrieve or playback mode.
// - playback destination bit routes data to scaling inputs or baseband chain.
// - parallel data input disabled while playing with baseband chain as playback destination.
// - enable, destination and segment fields act only on update or profile change.
// - upper 16 bits are I, lower 16 bits are Q.
// - chain words MSB aligned in 18 bits, two LSBs copy the sign.
// - scaling words are unsigned fractions from zero to one minus one LSB.
// - two segments, each start, end, 16-bit step rate and 3-bit mode.
// - step rate paces only scaling playback, ignored for chain playback.
// - addresses step with port accesses in load, data clock in chain playback, step timer in scaling playback.
// - address sequence follows the active segment mode field.
// - trigger pin watched always; any level change starts the sequencer.
// - rising edge selects segment 0, falling edge selects segment 1.
// - load counter advances with each word moved over the port.
// - load/retrieve counter only counts upward.
// - overlapping segments accepted, latest write wins.
// - mode codes 1 ramp-up, 2 bidirectional, 3 continuous bidirectional, 4 recirculate.
// - scaling playback delivers a sample every 4*R*M system clocks.
module waveform_ram_sequencer
    import wram_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int DEPTH = 1024
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic segment_trigger_pin,
    input wire logic io_update_pin,
    input wire logic [2:0] profile_pin,
    input wire logic bb_data_clk,
    output logic [15:0] i_scaling_input,
    output logic [15:0] q_scaling_input,
    output logic [17:0] bb_i,
    output logic [17:0] bb_q,
    output logic bb_sample_valid,
    output logic parallel_in_disable
);

    if (DEPTH != (1 << ADDR_W) || ADDR_W != 10) begin : g_bad_size
        $error("ram geometry must be 1024 words of 10-bit address");
    end

    // pin synchroniser: {profile, io_update, data clock, trigger}
    logic [5:0] pin_s1_ff;
    logic [5:0] pin_s2_ff;
    logic [5:0] pin_s3_ff;

    // no reset: history tracks the pins, so a pin high at release gives no edge
    always_ff @(posedge core_clk) begin
        pin_s1_ff <= {profile_pin, io_update_pin, bb_data_clk, segment_trigger_pin};
        pin_s2_ff <= pin_s1_ff;
        pin_s3_ff <= pin_s2_ff;
    end

    logic trig_rise;
    logic trig_fall;
    logic trig_evt;
    logic bb_tick;
    logic upd_pin_evt;
    logic prof_chg;

    assign trig_rise = pin_s2_ff[0] & ~pin_s3_ff[0];
    assign trig_fall = ~pin_s2_ff[0] & pin_s3_ff[0];
    assign trig_evt = trig_rise | trig_fall;
    assign bb_tick = pin_s2_ff[1] & ~pin_s3_ff[1];
    assign upd_pin_evt = pin_s2_ff[2] & ~pin_s3_ff[2];
    assign prof_chg = pin_s2_ff[5:3] != pin_s3_ff[5:3];

    // apb slave: one wait-free access phase, answer loaded in setup
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic setup;
    logic acc_done;
    logic wr_done;
    logic mapped;
    logic is_data;

    assign setup = apb_req.psel & ~apb_req.penable;
    assign acc_done = apb_req.psel & apb_req.penable & pready_ff;
    assign wr_done = acc_done & apb_req.pwrite & ~pslverr_ff;
    assign is_data = apb_req.paddr == `WRAM_OFF_DATA;

    always_comb begin
        unique case (apb_req.paddr)
            `WRAM_OFF_CTRL, `WRAM_OFF_SEG0_ADDR, `WRAM_OFF_SEG0_CFG,
            `WRAM_OFF_SEG1_ADDR, `WRAM_OFF_SEG1_CFG, `WRAM_OFF_UPDATE,
            `WRAM_OFF_DATA, `WRAM_OFF_STATUS, `WRAM_OFF_INTERP: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // staged settings written by software, active copies used by the sequencer
    ctrl_t ctrl_stage_ff;
    ctrl_t ctrl_act_ff;
    seg_t seg_stage_ff [2];
    seg_t seg_act_ff [2];
    logic [5:0] interp_ff;
    logic update_evt;
    logic ram_ok;
    logic playing;

    assign update_evt = upd_pin_evt | prof_chg
        | (wr_done && apb_req.paddr == `WRAM_OFF_UPDATE && apb_req.pwdata[0]);
    assign ram_ok = ctrl_act_ff.core_mode == `WRAM_CORE_QUAD
        || ctrl_act_ff.core_mode == `WRAM_CORE_INTERP;
    assign playing = ram_ok & ctrl_act_ff.enable;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_stage_ff <= '0;
            seg_stage_ff[0] <= '0;
            seg_stage_ff[1] <= '0;
            interp_ff <= `WRAM_INTERP_RST;
        end else if (wr_done) begin
            unique case (apb_req.paddr)
                `WRAM_OFF_CTRL: ctrl_stage_ff <= apb_req.pwdata[3:0];
                `WRAM_OFF_SEG0_ADDR: begin
                    seg_stage_ff[0].start_addr <= apb_req.pwdata[`WRAM_SEG_START_LSB +: 10];
                    seg_stage_ff[0].end_addr <= apb_req.pwdata[`WRAM_SEG_END_LSB +: 10];
                end
                `WRAM_OFF_SEG0_CFG: begin
                    seg_stage_ff[0].step <= apb_req.pwdata[`WRAM_SEG_STEP_LSB +: 16];
                    seg_stage_ff[0].mode <= apb_req.pwdata[`WRAM_SEG_MODE_LSB +: 3];
                end
                `WRAM_OFF_SEG1_ADDR: begin
                    seg_stage_ff[1].start_addr <= apb_req.pwdata[`WRAM_SEG_START_LSB +: 10];
                    seg_stage_ff[1].end_addr <= apb_req.pwdata[`WRAM_SEG_END_LSB +: 10];
                end
                `WRAM_OFF_SEG1_CFG: begin
                    seg_stage_ff[1].step <= apb_req.pwdata[`WRAM_SEG_STEP_LSB +: 16];
                    seg_stage_ff[1].mode <= apb_req.pwdata[`WRAM_SEG_MODE_LSB +: 3];
                end
                `WRAM_OFF_INTERP: interp_ff <= apb_req.pwdata[5:0];
                default: ;
            endcase
        end
    end

    // a write in the same cycle as the update is not yet seen by it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_act_ff <= '0;
            seg_act_ff[0] <= '0;
            seg_act_ff[1] <= '0;
        end else if (update_evt) begin
            ctrl_act_ff <= ctrl_stage_ff;
            seg_act_ff[0] <= seg_stage_ff[0];
            seg_act_ff[1] <= seg_stage_ff[1];
        end
    end

    // waveform storage
    logic [31:0] mem [DEPTH];

    // load/retrieve counter, paced by data-register accesses
    logic [ADDR_W-1:0] lr_addr_ff;
    logic lr_done_ff;
    logic lr_seg_ff;
    logic ram_acc;

    assign ram_acc = acc_done & is_data & ~pslverr_ff & ~lr_done_ff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lr_addr_ff <= '0;
            lr_done_ff <= 1'b1;
            lr_seg_ff <= 1'b0;
        end else if (trig_evt && !ctrl_act_ff.enable) begin
            lr_seg_ff <= trig_fall;
            lr_addr_ff <= seg_act_ff[trig_fall].start_addr;
            lr_done_ff <= 1'b0;
        end else if (ram_acc) begin
            if (lr_addr_ff == seg_act_ff[lr_seg_ff].end_addr) begin
                lr_done_ff <= 1'b1;
            end else begin
                lr_addr_ff <= lr_addr_ff + 1'b1;
            end
        end
    end

    // later writes simply overwrite earlier ones where segments overlap
    always_ff @(posedge core_clk) begin
        if (ram_acc && apb_req.pwrite) begin
            mem[lr_addr_ff] <= apb_req.pwdata;
        end
    end

    // playback sequencer
    pb_state_t pb_state_ff;
    logic [ADDR_W-1:0] play_addr_ff;
    logic dir_up_ff;
    logic seg_sel_ff;
    logic zero_hold_ff;
    logic [23:0] timer_ff;
    logic [23:0] period;
    logic [23:0] tmr_lim;
    logic step;
    logic [ADDR_W-1:0] nxt_play_addr;
    logic nxt_dir_up;
    logic nxt_halt;
    seg_t cur;

    assign cur = seg_act_ff[seg_sel_ff];
    assign period = {22'(interp_ff * cur.step), 2'b00};
    assign tmr_lim = (period == 24'h000000) ? 24'h000000 : period - 24'h000001;
    assign step = ctrl_act_ff.to_chain ? bb_tick : (timer_ff == tmr_lim);

    always_comb begin
        nxt_play_addr = play_addr_ff;
        nxt_dir_up = dir_up_ff;
        nxt_halt = 1'b0;
        unique case (cur.mode)
            `WRAM_MODE_RAMP_UP, `WRAM_MODE_BIDIR: begin
                if (dir_up_ff) begin
                    nxt_halt = play_addr_ff == cur.end_addr;
                    nxt_play_addr = nxt_halt ? play_addr_ff : play_addr_ff + 1'b1;
                end else begin
                    nxt_halt = play_addr_ff == cur.start_addr;
                    nxt_play_addr = nxt_halt ? play_addr_ff : play_addr_ff - 1'b1;
                end
            end
            `WRAM_MODE_CONT_BIDIR: begin
                // continuous modes fall back to a single ramp toward the scaling inputs
                if (!ctrl_act_ff.to_chain && play_addr_ff == cur.end_addr) begin
                    nxt_halt = 1'b1;
                end else if (dir_up_ff) begin
                    nxt_dir_up = play_addr_ff != cur.end_addr;
                    nxt_play_addr = nxt_dir_up ? play_addr_ff + 1'b1 : play_addr_ff - 1'b1;
                end else begin
                    nxt_dir_up = play_addr_ff == cur.start_addr;
                    nxt_play_addr = nxt_dir_up ? play_addr_ff + 1'b1 : play_addr_ff - 1'b1;
                end
            end
            `WRAM_MODE_RECIRC: begin
                if (play_addr_ff != cur.end_addr) begin
                    nxt_play_addr = play_addr_ff + 1'b1;
                end else if (ctrl_act_ff.to_chain) begin
                    nxt_play_addr = cur.start_addr;
                end else begin
                    nxt_halt = 1'b1;
                end
            end
            default: nxt_halt = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pb_state_ff <= PB_IDLE;
            play_addr_ff <= '0;
            dir_up_ff <= 1'b1;
            seg_sel_ff <= 1'b0;
            zero_hold_ff <= 1'b1;
            timer_ff <= 24'h000000;
        end else if (!playing || update_evt) begin
            pb_state_ff <= PB_IDLE;
            zero_hold_ff <= 1'b1;
            timer_ff <= 24'h000000;
        end else if (trig_evt) begin
            seg_sel_ff <= trig_fall;
            timer_ff <= 24'h000000;
            zero_hold_ff <= 1'b0;
            if (trig_fall && seg_act_ff[1].mode == `WRAM_MODE_BIDIR) begin
                play_addr_ff <= seg_act_ff[1].end_addr;
                dir_up_ff <= 1'b0;
            end else begin
                play_addr_ff <= seg_act_ff[trig_fall].start_addr;
                dir_up_ff <= 1'b1;
            end
            pb_state_ff <= PB_RUN;
        end else begin
            unique case (pb_state_ff)
                PB_RUN: begin
                    timer_ff <= step ? 24'h000000 : timer_ff + 24'h000001;
                    if (step) begin
                        play_addr_ff <= nxt_play_addr;
                        dir_up_ff <= nxt_dir_up;
                        if (nxt_halt) begin
                            pb_state_ff <= PB_HALT;
                        end
                    end
                end
                PB_IDLE, PB_HALT: timer_ff <= 24'h000000;
            endcase
        end
    end

    // delivery: each step presents the word at the current address
    logic [15:0] i_scal_ff;
    logic [15:0] q_scal_ff;
    logic [17:0] bb_i_ff;
    logic [17:0] bb_q_ff;
    logic bb_valid_ff;
    logic par_dis_ff;
    logic [31:0] word;
    logic deliver;

    assign word = mem[play_addr_ff];
    assign deliver = playing & ~update_evt & ~trig_evt & step & (pb_state_ff == PB_RUN);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            i_scal_ff <= 16'h0000;
            q_scal_ff <= 16'h0000;
            bb_i_ff <= 18'h00000;
            bb_q_ff <= 18'h00000;
            bb_valid_ff <= 1'b0;
        end else begin
            bb_valid_ff <= deliver & ctrl_act_ff.to_chain;
            if (!playing || zero_hold_ff || ctrl_act_ff.to_chain) begin
                i_scal_ff <= 16'h0000;
                q_scal_ff <= 16'h0000;
            end else if (deliver) begin
                i_scal_ff <= word[31:16];
                q_scal_ff <= word[15:0];
            end
            if (!playing || !ctrl_act_ff.to_chain) begin
                bb_i_ff <= 18'h00000;
                bb_q_ff <= 18'h00000;
            end else if (deliver) begin
                bb_i_ff <= {word[31:16], {2{word[31]}}};
                bb_q_ff <= {word[15:0], {2{word[15]}}};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            par_dis_ff <= 1'b0;
        end else begin
            par_dis_ff <= playing & ctrl_act_ff.to_chain;
        end
    end

    // apb answer, loaded in the setup cycle; ram access outside usable modes errs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                pslverr_ff <= !mapped || (is_data && !ram_ok);
                unique case (apb_req.paddr)
                    `WRAM_OFF_CTRL: prdata_ff <= {28'h0000000, ctrl_stage_ff};
                    `WRAM_OFF_SEG0_ADDR: prdata_ff <= {6'h00, seg_stage_ff[0].end_addr,
                        6'h00, seg_stage_ff[0].start_addr};
                    `WRAM_OFF_SEG0_CFG: prdata_ff <= {13'h0000, seg_stage_ff[0].mode,
                        seg_stage_ff[0].step};
                    `WRAM_OFF_SEG1_ADDR: prdata_ff <= {6'h00, seg_stage_ff[1].end_addr,
                        6'h00, seg_stage_ff[1].start_addr};
                    `WRAM_OFF_SEG1_CFG: prdata_ff <= {13'h0000, seg_stage_ff[1].mode,
                        seg_stage_ff[1].step};
                    `WRAM_OFF_DATA: prdata_ff <= (ram_ok && !lr_done_ff) ? mem[lr_addr_ff]
                        : 32'h00000000;
                    `WRAM_OFF_STATUS: prdata_ff <= {4'h0, lr_seg_ff, lr_done_ff, lr_addr_ff,
                        2'h0, pb_state_ff, ram_ok, seg_sel_ff, play_addr_ff};
                    `WRAM_OFF_INTERP: prdata_ff <= {26'h0000000, interp_ff};
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign i_scaling_input = i_scal_ff;
    assign q_scaling_input = q_scal_ff;
    assign bb_i = bb_i_ff;
    assign bb_q = bb_q_ff;
    assign bb_sample_valid = bb_valid_ff;
    assign parallel_in_disable = par_dis_ff;

endmodule : waveform_ram_sequencer

/* File: hw/wram_consts.svh */
// register offsets, field positions, reset values and codes of the waveform ram sequencer
`ifndef WRAM_CONSTS_SVH
`define WRAM_CONSTS_SVH

`define WRAM_OFF_CTRL 8'h00
`define WRAM_OFF_SEG0_ADDR 8'h04
`define WRAM_OFF_SEG0_CFG 8'h08
`define WRAM_OFF_SEG1_ADDR 8'h0c
`define WRAM_OFF_SEG1_CFG 8'h10
`define WRAM_OFF_UPDATE 8'h14
`define WRAM_OFF_DATA 8'h18
`define WRAM_OFF_STATUS 8'h1c
`define WRAM_OFF_INTERP 8'h20

`define WRAM_CTRL_ENABLE_BIT 0
`define WRAM_CTRL_DEST_BIT 1
`define WRAM_CTRL_CORE_LSB 2
`define WRAM_SEG_START_LSB 0
`define WRAM_SEG_END_LSB 16
`define WRAM_SEG_STEP_LSB 0
`define WRAM_SEG_MODE_LSB 16

`define WRAM_CORE_TONE 2'h0
`define WRAM_CORE_QUAD 2'h1
`define WRAM_CORE_INTERP 2'h2

`define WRAM_MODE_RAMP_UP 3'h1
`define WRAM_MODE_BIDIR 3'h2
`define WRAM_MODE_CONT_BIDIR 3'h3
`define WRAM_MODE_RECIRC 3'h4

`define WRAM_INTERP_RST 6'h01
`define WRAM_TIMER_SCALE 2

`endif

/* File: hw/wram_pkg.sv */
// types shared by the waveform ram sequencer
package wram_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [1:0] core_mode;
        logic to_chain;
        logic enable;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [15:0] step;
        logic [9:0] end_addr;
        logic [9:0] start_addr;
    } seg_t;

    typedef enum logic [1:0] {
        PB_IDLE,
        PB_RUN,
        PB_HALT
    } pb_state_t;

endpackage : wram_pkg

/* File: sim/wram_assertions.sv */
// port checker for the waveform ram sequencer, bound to the top module
`timescale 1ns/1ps
`include "wram_consts.svh"
module wram_checker
    import wram_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic io_update_pin,
    input wire logic [2:0] profile_pin,
    input wire logic [15:0] i_scaling_input,
    input wire logic [15:0] q_scaling_input,
    input wire logic [17:0] bb_i,
    input wire logic [17:0] bb_q,
    input wire logic bb_sample_valid,
    input wire logic parallel_in_disable
);
    logic [3:0] upd_age_ff;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // raw pin events; the synchronisers add a few cycles, hence the loose bound below
    always_ff @(posedge core_clk) begin
        if (rst) begin
            upd_age_ff <= 4'hf;
        end else if ($rose(io_update_pin) || $changed(profile_pin) ||
                (apb_req.psel && apb_req.pwrite && apb_req.paddr == `WRAM_OFF_UPDATE)) begin
            upd_age_ff <= 4'h0;
        end else if (upd_age_ff != 4'hf) begin
            upd_age_ff <= upd_age_ff + 4'h1;
        end
    end
    setup_answer_a: assert property (apb_req.psel && !apb_req.penable |=> pready)
        else $error("no answer after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    chain_sign_a: assert property (bb_sample_valid |->
        bb_i[1:0] == {2{bb_i[17]}} && bb_q[1:0] == {2{bb_q[17]}})
        else $error("chain sample not sign filled");
    chain_pin_a: assert property (bb_sample_valid |-> parallel_in_disable)
        else $error("parallel input open during chain playback");
    dest_excl_a: assert property (parallel_in_disable |->
        i_scaling_input == 16'h0 && q_scaling_input == 16'h0)
        else $error("scaling driven while chain selected");
    chain_gap_a: assert property (bb_sample_valid |=> !bb_sample_valid [*3])
        else $error("chain samples faster than data clock");
    update_only_a: assert property ($changed(parallel_in_disable) |-> upd_age_ff < 4'hc)
        else $error("destination changed without update");
    cover property (bb_sample_valid);
    cover property (i_scaling_input != 16'h0);
    cover property (pready && pslverr);
endmodule : wram_checker

bind waveform_ram_sequencer wram_checker i_chk (.core_clk, .rst, .apb_req, .prdata, .pready,
    .pslverr, .io_update_pin, .profile_pin, .i_scaling_input, .q_scaling_input, .bb_i, .bb_q,
    .bb_sample_valid, .parallel_in_disable);

/* File: sim/pin_host.sv */
// host model for the pin side: trigger, update, profile and baseband clock
`timescale 1ns/1ps
module pin_host (
    input wire logic core_clk,
    output logic segment_trigger_pin,
    output logic io_update_pin,
    output logic [2:0] profile_pin,
    output logic bb_data_clk
);
    logic bb_run = 1'b0;
    logic [1:0] div_ff = 2'h0;
    initial begin
        segment_trigger_pin = 1'b0;
        io_update_pin = 1'b0;
        profile_pin = 3'h0;
        bb_data_clk = 1'b0;
    end
    // data clock at core/8 and parked low when not running, so no stray steps
    always @(posedge core_clk) begin
        if (!bb_run) begin
            div_ff <= 2'h0;
            bb_data_clk <= 1'b0;
        end else begin
            div_ff <= div_ff + 2'h1;
            if (div_ff == 2'h3) bb_data_clk <= ~bb_data_clk;
        end
    end
    task automatic trig(input logic lvl);
        @(posedge core_clk);
        segment_trigger_pin <= lvl;
        repeat (6) @(posedge core_clk);
    endtask : trig
    task automatic pulse_update();
        @(posedge core_clk);
        io_update_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        io_update_pin <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : pulse_update
    task automatic set_profile(input logic [2:0] p);
        @(posedge core_clk);
        profile_pin <= p;
        repeat (8) @(posedge core_clk);
    endtask : set_profile
    task automatic run(input logic on);
        @(posedge core_clk);
        bb_run <= on;
    endtask : run
endmodule : pin_host

/* File: sim/testbench.sv */
// self-checking bench for the waveform ram sequencer
`timescale 1ns/1ps
`include "wram_consts.svh"
module testbench import wram_pkg::*;;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic e;
    } row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    apb_req_t apb_req = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, bb_sample_valid, parallel_in_disable;
    logic segment_trigger_pin, io_update_pin, bb_data_clk;
    logic [2:0] profile_pin;
    logic [15:0] i_scaling_input, q_scaling_input;
    logic [17:0] bb_i, bb_q;
    logic [35:0] smp [0:5];
    logic [2:0] modes [0:4];
    int counts [0:4];
    int rb [0:3];
    int err_count = 0;
    int cmp_count = 0;
    int n, cnt;
    row_t rows [0:15];
    waveform_ram_sequencer i_dut (.core_clk, .rst, .apb_req, .prdata, .pready, .pslverr,
        .segment_trigger_pin, .io_update_pin, .profile_pin, .bb_data_clk, .i_scaling_input,
        .q_scaling_input, .bb_i, .bb_q, .bb_sample_valid, .parallel_in_disable);
    pin_host i_host (.core_clk, .segment_trigger_pin, .io_update_pin, .profile_pin,
        .bb_data_clk);
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic timeout_out(input string what);
        err_count++;
        $display("wrong value %s expected response seen timeout", what);
        close_out();
    endtask : timeout_out
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout_out("pready");
        rd = prdata;
        er = pslverr;
        apb_req <= '0;
        @(posedge core_clk);
    endtask : apb
    task automatic wait_i(input logic [15:0] v, input logic eq);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((i_scaling_input === v) != eq && n < 300);
        if ((i_scaling_input === v) != eq) timeout_out("scaling sample");
    endtask : wait_i
    function automatic logic [31:0] wd(input int k);
        return {8'h90, 8'(k), 8'h01, 8'(k)};
    endfunction : wd
    function automatic logic [35:0] chain(input logic [31:0] w);
        return {w[31:16], {2{w[31]}}, w[15:0], {2{w[15]}}};
    endfunction : chain
    initial begin
        // segment ends kept above their starts
        rows = '{'{1'b0, `WRAM_OFF_INTERP, 32'h0, 32'h1, 1'b0},
            '{1'b1, `WRAM_OFF_SEG1_ADDR, 32'h03ff_03fe, 32'h0, 1'b0},
            '{1'b0, `WRAM_OFF_SEG1_ADDR, 32'h0, 32'h03ff_03fe, 1'b0},
            '{1'b1, `WRAM_OFF_SEG0_ADDR, 32'h0013_0010, 32'h0, 1'b0},
            '{1'b0, `WRAM_OFF_SEG0_ADDR, 32'h0, 32'h0013_0010, 1'b0},
            '{1'b1, `WRAM_OFF_SEG0_CFG, 32'h0001_0001, 32'h0, 1'b0},
            '{1'b0, `WRAM_OFF_SEG0_CFG, 32'h0, 32'h0001_0001, 1'b0},
            '{1'b1, `WRAM_OFF_SEG1_ADDR, 32'h0015_0012, 32'h0, 1'b0},
            '{1'b1, `WRAM_OFF_SEG1_CFG, 32'h0004_0001, 32'h0, 1'b0},
            '{1'b0, `WRAM_OFF_SEG1_CFG, 32'h0, 32'h0004_0001, 1'b0},
            '{1'b1, `WRAM_OFF_DATA, 32'h1234, 32'h0, 1'b1},
            '{1'b0, 8'h24, 32'h0, 32'h0, 1'b1},
            '{1'b1, 8'h24, 32'h5, 32'h0, 1'b1},
            '{1'b1, `WRAM_OFF_CTRL, 32'h4, 32'h0, 1'b0},
            '{1'b0, `WRAM_OFF_CTRL, 32'h0, 32'h4, 1'b0},
            '{1'b1, `WRAM_OFF_UPDATE, 32'h1, 32'h0, 1'b0}};
        modes = '{`WRAM_MODE_RAMP_UP, `WRAM_MODE_BIDIR, `WRAM_MODE_CONT_BIDIR,
            `WRAM_MODE_RECIRC, 3'h0};
        counts = '{4, 4, 6, 6, 1};
        rb = '{0, 1, 4, 5};
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 16; k++) begin
            apb(rows[k].w, rows[k].a, rows[k].d);
            chk(er, rows[k].e, "pslverr");
            if (!rows[k].w) chk(rd, rows[k].q, "prdata");
        end
        // load seg0, then the overlapping seg1, then read seg0 back
        i_host.trig(1'b1);
        for (int k = 0; k < 4; k++) apb(1'b1, `WRAM_OFF_DATA, wd(k));
        apb(1'b1, `WRAM_OFF_DATA, 32'hdead_beef);
        chk(er, 1'b0, "late write");
        i_host.trig(1'b0);
        for (int k = 4; k < 8; k++) apb(1'b1, `WRAM_OFF_DATA, wd(k));
        apb(1'b0, `WRAM_OFF_STATUS, 32'h0);
        chk(rd[27:26], 2'b11, "load seg and done");
        i_host.trig(1'b1);
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, `WRAM_OFF_DATA, 32'h0);
            chk(rd, wd(rb[k]), "readback");
        end
        apb(1'b0, `WRAM_OFF_DATA, 32'h0);
        chk(rd, 32'h0, "read past end");
        // chain playback; a huge step rate must not slow it
        apb(1'b1, `WRAM_OFF_CTRL, 32'h7);
        repeat (10) @(posedge core_clk);
        chk(parallel_in_disable, 1'b0, "staged destination");
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, `WRAM_OFF_SEG0_CFG, {13'h0, modes[m], 16'hffff});
            i_host.pulse_update();
            chk(parallel_in_disable, 1'b1, "parallel disable");
            i_host.trig(1'b0);
            i_host.trig(1'b1);
            i_host.run(1'b1);
            cnt = 0;
            for (int c = 0; c < 200; c++) begin
                @(posedge core_clk);
                if (bb_sample_valid === 1'b1) begin
                    if (cnt < 6) smp[cnt] = {bb_i, bb_q};
                    cnt++;
                end
            end
            i_host.run(1'b0);
            chk(36'(cnt > 6 ? 6 : cnt), 36'(counts[m]), "sample count");
            chk(smp[0], chain(wd(0)), "first sample");
            if (counts[m] > 1) chk(smp[1], chain(wd(1)), "second sample");
            if (m == 3) chk(smp[4], chain(wd(0)), "wrapped sample");
        end
        // scaling playback, R=2 and M=3 give a 24 cycle interval
        apb(1'b1, `WRAM_OFF_CTRL, 32'h5);
        apb(1'b1, `WRAM_OFF_SEG0_CFG, {13'h0, `WRAM_MODE_RAMP_UP, 16'h3});
        apb(1'b1, `WRAM_OFF_INTERP, 32'h2);
        i_host.set_profile(3'h5);
        chk(i_scaling_input, 16'h0, "static zero");
        i_host.trig(1'b0);
        i_host.trig(1'b1);
        wait_i(16'h9000, 1'b1);
        chk(q_scaling_input, 16'h0100, "q sample");
        wait_i(16'h9000, 1'b0);
        chk(36'(n), 36'(24), "sample interval");
        chk(i_scaling_input, 16'h9001, "i sample");
        i_host.pulse_update();
        chk(i_scaling_input, 16'h0, "zero after update");
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk({pready, i_scaling_input, parallel_in_disable}, 36'h0, "reset outputs");
        apb(1'b0, `WRAM_OFF_STATUS, 32'h0);
        chk(rd, 32'h0400_0000, "status after reset");
        apb(1'b1, `WRAM_OFF_CTRL, 32'h8);
        apb(1'b1, `WRAM_OFF_UPDATE, 32'h1);
        apb(1'b0, `WRAM_OFF_DATA, 32'h0);
        chk(er, 1'b0, "interp mode access");
        close_out();
    end
endmodule : testbench
